/* design/sync_serial.sv */
// Purpose: Clock synchronous serial channel with AHB-Lite register access
// Assumes: Pin inputs synchronous to clock; external clock slow against clock
// Notes: One channel with all per-channel options present
//
// Summary of operation
// - Each word is exactly eight data bits, no framing bits.
// - Internal transfer clock is source clock divided by 2(n+1); f1, f8, f32.
// - Clock select 1 takes transfer clock from clock pin.
// - Divider value n spans the full byte 0 to 255.
// - Transmit starts with enable set, buffer loaded, and CTS low if selected.
// - Receive needs receive enable, transmit enable and loaded transmit buffer.
// - Cause select 0: transmit interrupt on buffer-to-shifter move.
// - Cause select 1: transmit interrupt after the word is sent.
// - Receive interrupt when a word moves into the receive buffer.
// - Overrun flagged when a word arrives before the previous one is read.
// - On overrun buffer is overwritten, receive interrupt not set.
// - Clock polarity picks the edges for driving and sampling data.
// - Bit order picks LSB first or MSB first, both directions.
// - Continuous receive: reading receive buffer re-enables reception.
// - Channel one: internal clock routed to one of two output pins.
// - Channel zero: CTS and RTS on separate pins.
// - Dual clock pins and separate handshake pins are mutually exclusive.
// - Channel two: data inverted on buffer write and buffer read.
// - Channel two: serial output and input pin levels inverted.
// - Handshake is CTS input, RTS output, or disabled.
// - Output pin sits high, or floats if open-drain, until first transfer.
// - Receive-only operation still shifts out the dummy data.
module sync_serial
  import sync_serial_pkg::*;
#(
  parameter int div_w = 8
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic clk_pin_in,
  output logic clk_pin_out,
  output logic clk_pin_oe_b,
  output logic clk_alt_out,
  output logic clk_alt_oe_b,
  input wire logic serial_in_pin,
  output logic serial_out_pin,
  output logic serial_out_oe_b,
  input wire logic cts_b,
  output logic rts_b,
  output logic rts_alt_b,
  output logic tx_irq,
  output logic rx_irq
);
  // ==========================================================
  // Reset release
  logic rst_s1_r, rst_sync_b;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_r <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_sync_b <= rst_s1_r;
    end
  end

  // ==========================================================
  // Bus slave
  logic ph_wr_r, ph_rd_r;
  logic [7:0] ph_addr_r;
  logic [ctl_width-1:0] ctrl_r;
  logic [div_w-1:0] rate_r;
  logic [7:0] txbuf_r, rxbuf_r, tx_shift_r, rx_shift_r;
  logic tx_empty_r, rx_full_r, overrun_r, tx_irq_st_r, rx_irq_st_r, rx_armed_r;
  shift_state_t state_r;
  logic take;
  assign take = hsel && hready && htrans == htrans_nonseq;
  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      ph_wr_r <= 1'b0;
      ph_rd_r <= 1'b0;
      ph_addr_r <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      ph_wr_r <= take && hwrite;
      ph_rd_r <= take && !hwrite;
      ph_addr_r <= take ? haddr : ph_addr_r;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end
  // Reads are answered from the address phase so hrdata is a flop in the data phase
  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      hrdata <= 32'h0;
    end else if (take && !hwrite) begin
      case (haddr)
        ctrl_off: hrdata <= 32'(ctrl_r);
        rate_off: hrdata <= 32'(rate_r);
        txbuf_off: hrdata <= 32'(txbuf_r);
        rxbuf_off: hrdata <= 32'(ctrl_r[ctl_data_inv] ? ~rxbuf_r : rxbuf_r);
        stat_off: hrdata <= 32'({state_r == st_shift, rx_irq_st_r, tx_irq_st_r, overrun_r, rx_full_r, tx_empty_r});
        default: hrdata <= 32'h0;
      endcase
    end
  end
  logic wr_ctrl, wr_rate, wr_tx, rd_rx, wr_stat;
  assign wr_ctrl = ph_wr_r && ph_addr_r == ctrl_off;
  assign wr_rate = ph_wr_r && ph_addr_r == rate_off;
  assign wr_tx = ph_wr_r && ph_addr_r == txbuf_off;
  assign wr_stat = ph_wr_r && ph_addr_r == stat_off;
  assign rd_rx = ph_rd_r && ph_addr_r == rxbuf_off;

  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      ctrl_r <= ctrl_rst;
      rate_r <= div_w'(rate_rst);
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= hwdata[ctl_width-1:0];
        if (hwdata[ctl_sep_hs]) ctrl_r[ctl_clk_multi] <= 1'b0;
      end
      if (wr_rate) rate_r <= hwdata[div_w-1:0];
    end
  end

  // ==========================================================
  // Transfer clock
  logic ext_clk, pol, msb, cont;
  assign ext_clk = ctrl_r[ctl_ext_clk];
  assign pol = ctrl_r[ctl_clk_pol];
  assign msb = ctrl_r[ctl_msb_first];
  assign cont = ctrl_r[ctl_cont_rx];
  logic [4:0] pre_r;
  logic [div_w-1:0] div_r;
  logic tick;
  logic pre_hit;
  always_comb begin
    case (ctrl_r[ctl_src_lo +: 2])
      src_f1: pre_hit = 1'b1;
      src_f8: pre_hit = pre_r[2:0] == 3'h7;
      src_f32: pre_hit = pre_r == 5'h1f;
      default: pre_hit = 1'b1;
    endcase
  end
  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      pre_r <= 5'h0;
      div_r <= '0;
    end else if (state_r != st_shift) begin
      pre_r <= 5'h0;
      div_r <= '0;
    end else begin
      pre_r <= pre_r + 5'h1;
      if (pre_hit) div_r <= (div_r == rate_r) ? '0 : div_r + 1'b1;
    end
  end
  // Half period is (n+1) source cycles, so a full period is 2(n+1)
  assign tick = state_r == st_shift && pre_hit && div_r == rate_r;

  logic ext_s_r, ext_prev_r;
  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      ext_s_r <= 1'b1;
      ext_prev_r <= 1'b1;
    end else begin
      ext_s_r <= clk_pin_in;
      ext_prev_r <= ext_s_r;
    end
  end
  // Idle level is high for polarity 0; the partner keeps it there
  logic idle_lvl, int_clk_r, clk_lvl, clk_prev;
  assign idle_lvl = ~pol;
  assign clk_lvl = ext_clk ? ext_s_r : int_clk_r;
  assign clk_prev = ext_clk ? ext_prev_r : ~int_clk_r;
  logic drive_edge, sample_edge;
  // Leaving idle level drives, returning to it samples
  assign drive_edge = ext_clk ? (ext_s_r != ext_prev_r && ext_s_r != idle_lvl) : (tick && int_clk_r == idle_lvl);
  assign sample_edge = ext_clk ? (ext_s_r != ext_prev_r && ext_s_r == idle_lvl) : (tick && int_clk_r != idle_lvl);

  // ==========================================================
  // Shifter
  logic [3:0] bit_cnt_r;
  logic cts_ok, tx_ok, rx_ok, start;
  logic [1:0] hs;
  assign hs = ctrl_r[ctl_hs_lo +: 2];
  assign cts_ok = hs != hs_cts || !cts_b;
  assign tx_ok = ctrl_r[ctl_tx_en] && !tx_empty_r && cts_ok;
  assign rx_ok = !ctrl_r[ctl_rx_en] || rx_armed_r;
  assign start = state_r == st_idle && tx_ok && rx_ok && (!ext_clk || ext_s_r == idle_lvl);
  logic in_bit;
  assign in_bit = ctrl_r[ctl_line_inv] ? ~serial_in_pin : serial_in_pin;
  logic done;
  assign done = sample_edge && bit_cnt_r == 4'(word_bits - 1);

  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      state_r <= st_idle;
      bit_cnt_r <= 4'h0;
      tx_shift_r <= 8'h0;
      rx_shift_r <= 8'h0;
      int_clk_r <= 1'b1;
    end else begin
      case (state_r)
        st_idle: begin
          int_clk_r <= idle_lvl;
          bit_cnt_r <= 4'h0;
          if (start) begin
            state_r <= st_shift;
            tx_shift_r <= txbuf_r;
          end
        end
        st_shift: begin
          if (!ext_clk && tick) int_clk_r <= ~int_clk_r;
          if (drive_edge && bit_cnt_r != 4'h0)
            tx_shift_r <= msb ? {tx_shift_r[6:0], 1'b0} : {1'b0, tx_shift_r[7:1]};
          if (sample_edge) begin
            rx_shift_r <= msb ? {rx_shift_r[6:0], in_bit} : {in_bit, rx_shift_r[7:1]};
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end
          if (done) state_r <= st_idle;
        end
        default: state_r <= st_idle;
      endcase
    end
  end

  // ==========================================================
  // Buffers and flags; hardware set wins over software clear
  logic [7:0] rx_word, tx_wdata;
  assign rx_word = msb ? {rx_shift_r[6:0], in_bit} : {in_bit, rx_shift_r[7:1]};
  assign tx_wdata = ctrl_r[ctl_data_inv] ? ~hwdata[7:0] : hwdata[7:0];
  logic rx_store;
  assign rx_store = done && ctrl_r[ctl_rx_en];
  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      txbuf_r <= 8'h0;
      tx_empty_r <= 1'b1;
    end else begin
      if (wr_tx) txbuf_r <= tx_wdata;
      if (start) tx_empty_r <= 1'b1;
      // Continuous mode reuses the held dummy word, so a buffer read counts as loaded
      else if (wr_tx || (cont && rd_rx)) tx_empty_r <= 1'b0;
    end
  end
  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      rxbuf_r <= 8'h0;
      rx_full_r <= 1'b0;
      overrun_r <= 1'b0;
      rx_armed_r <= 1'b0;
    end else begin
      if (rx_store) rxbuf_r <= rx_word;
      if (rx_store) rx_full_r <= 1'b1;
      else if (rd_rx) rx_full_r <= 1'b0;
      if (rx_store && rx_full_r && !rd_rx) overrun_r <= 1'b1;
      else if (wr_stat && hwdata[st_overrun]) overrun_r <= 1'b0;
      // Dummy write arms a reception; continuous mode rearms on buffer read
      if (wr_tx || (cont && rd_rx)) rx_armed_r <= 1'b1;
      else if (start && !cont) rx_armed_r <= 1'b0;
    end
  end
  logic tx_ev;
  assign tx_ev = ctrl_r[ctl_tx_cause] ? done : start;
  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      tx_irq_st_r <= 1'b0;
      rx_irq_st_r <= 1'b0;
      tx_irq <= 1'b0;
      rx_irq <= 1'b0;
    end else begin
      if (tx_ev) tx_irq_st_r <= 1'b1;
      else if (wr_stat && hwdata[st_tx_irq]) tx_irq_st_r <= 1'b0;
      if (rx_store && !(rx_full_r && !rd_rx)) rx_irq_st_r <= 1'b1;
      else if (wr_stat && hwdata[st_rx_irq]) rx_irq_st_r <= 1'b0;
      tx_irq <= tx_ev;
      rx_irq <= rx_store && !(rx_full_r && !rd_rx);
    end
  end

  // ==========================================================
  // Pins
  logic out_bit, run_clk;
  assign out_bit = msb ? tx_shift_r[7] : tx_shift_r[0];
  assign run_clk = !ext_clk;
  // Data leaves the idle level with the first clock edge, then holds the last bit
  // Holding avoids racing the partner's final sample against a return to idle
  logic out_en_r;
  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      out_en_r <= 1'b0;
    end else if (state_r == st_shift && drive_edge) begin
      out_en_r <= 1'b1;
    end
  end
  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      serial_out_pin <= 1'b1;
      serial_out_oe_b <= 1'b0;
      clk_pin_out <= 1'b1;
      clk_pin_oe_b <= 1'b0;
      clk_alt_out <= 1'b1;
      clk_alt_oe_b <= 1'b1;
      rts_b <= 1'b1;
      rts_alt_b <= 1'b1;
    end else begin
      if (out_en_r) begin
        serial_out_pin <= ctrl_r[ctl_line_inv] ? ~out_bit : out_bit;
        serial_out_oe_b <= ctrl_r[ctl_open_drain] && (out_bit ^ ctrl_r[ctl_line_inv]);
      end else begin
        serial_out_pin <= 1'b1;
        serial_out_oe_b <= ctrl_r[ctl_open_drain];
      end
      // Alternate pin only when multi-pin option on and internal clock
      clk_pin_out <= clk_lvl;
      clk_pin_oe_b <= !(run_clk && !(ctrl_r[ctl_clk_multi] && ctrl_r[ctl_clk_alt]));
      clk_alt_out <= clk_lvl;
      clk_alt_oe_b <= !(run_clk && ctrl_r[ctl_clk_multi] && ctrl_r[ctl_clk_alt]);
      // RTS low means ready to receive
      rts_b <= !(hs == hs_rts && !ctrl_r[ctl_sep_hs] && rx_ok && ctrl_r[ctl_rx_en]);
      rts_alt_b <= !(ctrl_r[ctl_sep_hs] && !ctrl_r[ctl_clk_multi] && rx_ok && ctrl_r[ctl_rx_en]);
    end
  end
endmodule

/* inc/sync_serial_pkg.sv */
// Purpose: Constants for the clock synchronous serial channel
// Assumes: AHB-Lite register access, 32-bit words, 250 MHz clock
// Notes: Offsets are byte addresses
package sync_serial_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] ctrl_off = 8'h00;
  localparam logic [7:0] rate_off = 8'h04;
  localparam logic [7:0] txbuf_off = 8'h08;
  localparam logic [7:0] rxbuf_off = 8'h0c;
  localparam logic [7:0] stat_off = 8'h10;
  // ==========================================================
  // Control bit positions
  localparam int ctl_tx_en = 0;
  localparam int ctl_rx_en = 1;
  localparam int ctl_ext_clk = 3;
  localparam int ctl_clk_pol = 6;
  localparam int ctl_msb_first = 7;
  localparam int ctl_hs_lo = 8;
  localparam int ctl_src_lo = 10;
  localparam int ctl_tx_cause = 12;
  localparam int ctl_cont_rx = 13;
  localparam int ctl_clk_alt = 14;
  localparam int ctl_clk_multi = 15;
  localparam int ctl_sep_hs = 16;
  localparam int ctl_data_inv = 17;
  localparam int ctl_line_inv = 18;
  localparam int ctl_open_drain = 19;
  localparam int ctl_width = 20;
  // Status bit positions
  localparam int st_tx_empty = 0;
  localparam int st_rx_full = 1;
  localparam int st_overrun = 2;
  localparam int st_tx_irq = 3;
  localparam int st_rx_irq = 4;
  localparam int st_busy = 5;
  localparam int st_width = 6;
  // ==========================================================
  // Encodings and reset values
  localparam logic [1:0] hs_off = 2'h0;
  localparam logic [1:0] hs_cts = 2'h1;
  localparam logic [1:0] hs_rts = 2'h2;
  localparam logic [1:0] src_f1 = 2'h0;
  localparam logic [1:0] src_f8 = 2'h1;
  localparam logic [1:0] src_f32 = 2'h2;
  localparam logic [19:0] ctrl_rst = 20'h00000;
  localparam logic [7:0] rate_rst = 8'h00;
  localparam int word_bits = 8;
  localparam logic [1:0] htrans_nonseq = 2'h2;
  typedef enum logic [1:0] {st_idle, st_shift} shift_state_t;
endpackage

/* testbench/clock_sync_serial_channel_tb.sv */
// Purpose: Self-checking bench for the synchronous serial channel
// Assumes: Internal clock except the external-clock test 7, polarity 0; partner on the clock and data pins
// Notes: Partner frames are checked against a queue of expected bytes
module clock_sync_serial_channel_tb
  import sync_serial_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
  logic clock = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0, cts_b = 1'b0, p_msb = 1'b0;
  logic ext_ck = 1'b1; // External clock rests high outside frames
  logic [7:0] haddr = 8'h00, p_tx = 8'h00, t, p_rx;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0, hrdata, rd;
  logic hreadyout, hresp, clk_pin_out, clk_pin_oe_b, clk_alt_out, clk_alt_oe_b;
  logic serial_out_pin, serial_out_oe_b, rts_b, rts_alt_b, tx_irq, rx_irq, p_sin;
  int frames, f, i0, fail_count = 0, tests_run = 0, irqs = 0, cyc = 0;
  logic [7:0] exp_q[$];
  sync_serial u_dut (.clock(clock), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .clk_pin_in(ext_ck), .clk_pin_out(clk_pin_out), .clk_pin_oe_b(clk_pin_oe_b), .clk_alt_out(clk_alt_out),
    .clk_alt_oe_b(clk_alt_oe_b), .serial_in_pin(p_sin), .serial_out_pin(serial_out_pin),
    .serial_out_oe_b(serial_out_oe_b), .cts_b(cts_b), .rts_b(rts_b), .rts_alt_b(rts_alt_b), .tx_irq(tx_irq),
    .rx_irq(rx_irq));
  serial_partner u_part (.clk_pin(clk_pin_out), .rst_b(rst_b), .sout(serial_out_pin), .msb(p_msb), .tx_byte(p_tx),
    .sin(p_sin), .rx_byte(p_rx), .frames(frames));
  // ==========================================================
  // Clock, watchdog and monitors
  initial forever #2 clock = ~clock;
  always @(posedge clock) begin
    cyc++;
    if (rx_irq === 1'b1) irqs++;
    if (cyc == 20000) begin
      fail_count++;
      final_report();
    end
  end
  // Continuous receive frames resend the held dummy word and push nothing, so an empty queue means no check
  always @(frames) begin
    #1;
    if (exp_q.size() != 0) `CHK(p_rx, exp_q.pop_front())
  end
  // ==========================================================
  // Tasks
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= htrans_nonseq;
    haddr <= a;
    hwrite <= wr;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    rd = hrdata;
  endtask
  task automatic send(input logic [7:0] w, input logic [7:0] e);
    int n;
    n = frames;
    p_tx = 8'($urandom);
    exp_q.push_back(e);
    ahb(1'b1, txbuf_off, {24'h0, w});
    while (frames < n + 1) @(posedge clock);
    repeat (4) @(posedge clock);
  endtask
  task automatic xfer(input logic [19:0] c, input logic [7:0] n, input logic inv);
    logic [7:0] w;
    w = 8'($urandom);
    p_msb = c[ctl_msb_first];
    ahb(1'b1, rate_off, {24'h0, n});
    ahb(1'b1, ctrl_off, {12'h000, c});
    send(w, inv ? ~w : w);
    ahb(1'b0, rxbuf_off, 32'h0);
    `CHK(rd[7:0], inv ? ~p_tx : p_tx)
  endtask
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(36));
    repeat (5) @(posedge clock);
    rst_b <= 1'b1;
    repeat (3) @(posedge clock);
    ahb(1'b0, ctrl_off, 32'h0);
    `CHK(rd[19:0], ctrl_rst)
    ahb(1'b0, stat_off, 32'h0);
    `CHK(rd[st_tx_empty], 1'b1)
    `CHK(serial_out_pin, 1'b1)
    `CHK(hresp, 1'b0)
    `CHK(clk_pin_oe_b, 1'b0)
    $display("test 1 done");
    xfer(20'h00403, 8'h00, 1'b0);
    xfer(20'h01083, 8'hff, 1'b0);
    xfer(20'h20803, 8'($urandom_range(1)), 1'b1);
    xfer(20'h40483, 8'($urandom_range(3)), 1'b1);
    $display("test 2 done");
    p_msb = 1'b0;
    i0 = irqs;
    ahb(1'b1, ctrl_off, 32'h00403);
    t = 8'($urandom);
    send(t, t);
    t = 8'($urandom);
    send(t, t);
    `CHK(irqs - i0, 1)
    ahb(1'b0, stat_off, 32'h0);
    `CHK(rd[st_overrun], 1'b1)
    ahb(1'b0, rxbuf_off, 32'h0);
    `CHK(rd[7:0], p_tx)
    ahb(1'b1, stat_off, 32'h1c);
    $display("test 3 done");
    ahb(1'b1, ctrl_off, 32'h02403);
    t = 8'($urandom);
    send(t, t);
    f = frames;
    ahb(1'b0, rxbuf_off, 32'h0);
    while (frames < f + 1) @(posedge clock);
    repeat (4) @(posedge clock);
    `CHK(frames, f + 1)
    ahb(1'b1, ctrl_off, 32'h00403);
    $display("test 4 done");
    cts_b <= 1'b1;
    ahb(1'b1, ctrl_off, 32'h01501);
    f = frames;
    t = 8'($urandom);
    exp_q.push_back(t);
    ahb(1'b1, txbuf_off, {24'h0, t});
    repeat (64) @(posedge clock);
    `CHK(frames, f)
    cts_b <= 1'b0;
    while (frames < f + 1) @(posedge clock);
    $display("test 5 done");
    ahb(1'b1, ctrl_off, 32'h0c000);
    ahb(1'b0, 8'h40, 32'h0);
    `CHK(clk_alt_oe_b, 1'b0)
    ahb(1'b1, ctrl_off, 32'h1c000);
    ahb(1'b0, 8'h40, 32'h0);
    `CHK(clk_alt_oe_b, 1'b1)
    $display("test 6 done");
    ahb(1'b1, ctrl_off, 32'h00009);
    f = frames;
    t = 8'($urandom);
    exp_q.push_back(t);
    ahb(1'b1, txbuf_off, {24'h0, t});
    repeat (16) begin
      repeat (8) @(posedge clock);
      ext_ck <= ~ext_ck;
    end
    repeat (8) @(posedge clock);
    `CHK(frames, f + 1)
    `CHK(clk_pin_oe_b, 1'b1)
    $display("test 7 done");
    final_report();
  end
endmodule

/* testbench/serial_partner.sv */
// Purpose: External serial device clocked by the channel
// Assumes: Polarity 0, data moves on falling and is taken on rising edge
// Notes: Line shows the inverse of its last bit between frames
module serial_partner (
  input wire logic clk_pin,
  input wire logic rst_b,
  input wire logic sout,
  input wire logic msb,
  input wire logic [7:0] tx_byte,
  output logic sin,
  output logic [7:0] rx_byte,
  output int frames
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] cnt = 3'h0;
  logic [7:0] sh = 8'h00;
  logic [7:0] nxt;
  initial sin = 1'b1;
  // ==========================================================
  // Shifting
  always @(negedge clk_pin) if (rst_b) sin <= tx_byte[msb ? 3'h7 - cnt : cnt];
  always @(posedge clk_pin) begin
    if (rst_b) begin
      nxt = msb ? {sh[6:0], sout} : {sout, sh[7:1]};
      sh <= nxt;
      cnt <= cnt + 3'h1;
      if (cnt == 3'h7) begin
        rx_byte <= nxt;
        frames <= frames + 1;
        sin <= ~sin;
      end
    end
  end
endmodule

/* testbench/sync_serial_chk.sv */
// Purpose: Port-level assertions for the synchronous serial channel
// Assumes: Internal transfer clock with polarity 0 while frames run
// Notes: Control and rate are shadowed from bus writes
module sync_serial_chk
  import sync_serial_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic clk_pin_out,
  input wire logic clk_alt_oe_b,
  input wire logic serial_out_pin,
  input wire logic serial_out_oe_b,
  input wire logic tx_irq,
  input wire logic rx_irq
);
  // ==========================================================
  // Shadow state
  logic aw_r, txwr_r, begun_r, alt_ok;
  logic [7:0] aa_r, rate_r;
  logic [19:0] ctl_r;
  logic [15:0] cnt_r, half;
  logic [2:0] rise_r;
  assign alt_ok = ctl_r[ctl_clk_multi] && ctl_r[ctl_clk_alt] && !ctl_r[ctl_sep_hs] && !ctl_r[ctl_ext_clk];
  assign half = ({8'h00, rate_r} + 16'h0001) *
    ((ctl_r[11:10] == src_f8) ? 16'h0008 : (ctl_r[11:10] == src_f32) ? 16'h0020 : 16'h0001);
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      aw_r <= 1'b0;
      aa_r <= 8'h00;
      txwr_r <= 1'b0;
      ctl_r <= ctrl_rst;
      rate_r <= rate_rst;
    end else begin
      aw_r <= hsel && hready && hwrite && htrans == htrans_nonseq;
      aa_r <= haddr;
      txwr_r <= aw_r && aa_r == txbuf_off;
      if (aw_r && aa_r == ctrl_off) ctl_r <= hwdata[19:0];
      if (aw_r && aa_r == rate_off) rate_r <= hwdata[7:0];
    end
  end
  // Edge spacing and bit count of the transfer clock
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= 16'h0000;
      rise_r <= 3'h0;
      begun_r <= 1'b0;
    end else begin
      cnt_r <= $changed(clk_pin_out) ? 16'h0001 : cnt_r + 16'h0001;
      if ($rose(clk_pin_out)) rise_r <= rise_r + 3'h1;
      begun_r <= begun_r | $fell(clk_pin_out);
    end
  end
  // ==========================================================
  // Properties
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  sequence s_tx_move;
    ##[1:6] tx_irq;
  endsequence
  sequence s_frame_end;
    (rise_r == 3'h7) && !clk_pin_out ##1 clk_pin_out;
  endsequence
  AST_IDLE_HIGH: assert property (!begun_r && !$fell(clk_pin_out) |-> serial_out_pin || serial_out_oe_b)
    else $error("output left idle level before first transfer");
  AST_HALF_PERIOD: assert property ($rose(clk_pin_out) && !ctl_r[ctl_ext_clk] && !ctl_r[ctl_clk_pol] |-> cnt_r == half)
    else $error("transfer clock half period wrong");
  AST_EIGHT_BITS: assert property (rx_irq |-> s_frame_end)
    else $error("receive done not after eight clocks");
  AST_TX_DONE: assert property (tx_irq && ctl_r[ctl_tx_cause] |-> s_frame_end)
    else $error("transmit request before word finished");
  AST_TX_MOVE: assert property (txwr_r && ctl_r[ctl_tx_en] && !ctl_r[ctl_tx_cause] |-> s_tx_move)
    else $error("no transmit request on buffer move");
  AST_NO_TX: assert property (!ctl_r[ctl_tx_en] |-> $stable(clk_pin_out))
    else $error("clock ran with transmit disabled");
  AST_SAMPLE: assert property ($rose(clk_pin_out) && half > 16'h0002 |-> $stable(serial_out_pin))
    else $error("data moved at sampling edge");
  AST_ALT_PIN: assert property (!clk_alt_oe_b |-> alt_ok || $past(alt_ok))
    else $error("alternate clock pin enabled wrongly");
endmodule

bind sync_serial sync_serial_chk u_chk (.clock(clock), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .clk_pin_out(clk_pin_out), .clk_alt_oe_b(clk_alt_oe_b),
  .serial_out_pin(serial_out_pin), .serial_out_oe_b(serial_out_oe_b), .tx_irq(tx_irq), .rx_irq(rx_irq));
